// File: fosr_pkg.sv
// Package for the flash operation status register block
package fosr_pkg;

  // ==========================================================
  // Status bit positions
  localparam int POS_READY    = 7;
  localparam int POS_ERS_SUSP = 6;
  localparam int POS_ERS_ERR  = 5;
  localparam int POS_PRG_ERR  = 4;
  localparam int POS_SUPPLY   = 3;
  localparam int POS_PRG_SUSP = 2;
  localparam int POS_PROTECT  = 1;

  // ==========================================================
  // Widths and reset values
  localparam int        STATUS_W        = 8;
  localparam int        PULSE_W         = 8;
  localparam logic [7:0] STATUS_RESET   = 8'h80;
  localparam logic [7:0] STICKY_MASK    = 8'h3A;
  localparam logic [7:0] RESERVED_VALUE = 8'h00;
  localparam logic [7:0] MAX_PULSES     = 8'h0A;
  // Two-cycle verify latency of the array sense path
  localparam int        VERIFY_NS       = 100;
  localparam int        CLK_NS          = 50;
  localparam int        VERIFY_CYC      = (VERIFY_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Command and state types
  typedef enum logic [1:0] {
    FOSR_OP_PROGRAM,
    FOSR_OP_ERASE
  } fosr_op_e;

  typedef enum {
    FOSR_IDLE,
    FOSR_PULSE,
    FOSR_VERIFY,
    FOSR_SUSP
  } fosr_state_e;

  typedef struct packed {
    logic     start;
    fosr_op_e op;
    logic     protected_blk;
    logic     suspend;
    logic     resume;
    logic     clear_status;
  } fosr_cmd_s;

endpackage

// File: fosr_sticky.sv
// Sticky error flag: set wins over clear
`timescale 1ns/1ns
module fosr_sticky (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Events
  input  wire logic set,
  input  wire logic clr,
  // Flag
  output logic      flag
);
  always_ff @(posedge clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

// File: fosr_status.sv
// Program/erase sequencer status word with sticky error flags
// Behaviour
// R1 - Supply sampled once at operation start
// R2 - Bit 3 set and abort on low supply
// R3 - Bit 3 held until clear or reset
// R4 - Pending sticky error fails new operations
// R5 - Host clears status before new operation
// R6 - Bit 2 shows program suspended
// R7 - Suspend flags valid only when ready
// R8 - Resume clears program suspend flag
// R9 - Bit 1 set, abort on protected block
// R10 - Bit 1 cleared only by clear/reset
// R11 - Bit 0 reserved, reads zero
// R12 - Bit 7 zero while busy
// R13 - Bit 6 erase suspended until resume
// R14 - Bit 5 erase failure after max pulses
// R15 - Bit 4 program verify failure
// R16 - Clear resets bits 5,4,3,1 only
`timescale 1ns/1ns
module fosr_status #(
  parameter int MAX_PULSE = int'(fosr_pkg::MAX_PULSES)
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Decoded commands
  input  wire fosr_pkg::fosr_cmd_s           cmd,
  // Array and supply
  input  wire logic                          supply_ok,
  input  wire logic                          verify_pass,
  // Status read port
  input  wire logic                          status_rd,
  output logic [fosr_pkg::STATUS_W-1:0]      status_dq,
  output logic [fosr_pkg::STATUS_W-1:0]      status_live,
  // Array control
  output logic                               pulse_en
);
  import fosr_pkg::*;

  // Pulse count must fit its counter and the verify wait its 2-bit counter
  if (MAX_PULSE < 1 || MAX_PULSE > (1 << PULSE_W) - 1 || VERIFY_CYC > 3) begin
    $error("MAX_PULSE or verify count out of range");
  end

  fosr_state_e          state_r;
  fosr_op_e             op_r;
  logic [PULSE_W-1:0]   pulses_r;
  logic [1:0]           vcnt_r;
  logic                 ers_susp_r;
  logic                 prg_susp_r;
  logic                 sticky_any;
  logic                 accept;
  logic                 abort_supply;
  logic                 abort_prot;
  logic                 set_ers;
  logic                 set_prg;
  logic                 ers_err;
  logic                 prg_err;
  logic                 sup_err;
  logic                 prot_err;
  logic                 clr;

  // ==========================================================
  // Start decision
  assign accept       = cmd.start && state_r == FOSR_IDLE;
  assign sticky_any   = ers_err | prg_err | sup_err | prot_err;
  // Supply is looked at only here, never during the run      [R1]
  assign abort_supply = accept && !supply_ok;                // [R2]
  assign abort_prot   = accept && supply_ok && cmd.protected_blk; // [R9]
  assign clr          = cmd.clear_status && state_r == FOSR_IDLE; // [R16]

  // Old error reported as a failure of the new command        [R4]
  assign set_prg = (accept && cmd.op == FOSR_OP_PROGRAM && sticky_any)
                 || (state_r == FOSR_VERIFY && vcnt_r == 2'(VERIFY_CYC)
                     && op_r == FOSR_OP_PROGRAM && !verify_pass);          // [R15]
  assign set_ers = (accept && cmd.op == FOSR_OP_ERASE && sticky_any)
                 || (state_r == FOSR_VERIFY && vcnt_r == 2'(VERIFY_CYC)
                     && op_r == FOSR_OP_ERASE && !verify_pass
                     && pulses_r >= PULSE_W'(MAX_PULSE));                  // [R14]

  // ==========================================================
  // Sticky flags
  fosr_sticky u_ers (.clk(clk), .rst(rst), .set(set_ers), .clr(clr), .flag(ers_err));
  fosr_sticky u_prg (.clk(clk), .rst(rst), .set(set_prg), .clr(clr), .flag(prg_err));
  fosr_sticky u_sup (.clk(clk), .rst(rst), .set(abort_supply), .clr(clr), .flag(sup_err)); // [R3]
  fosr_sticky u_prt (.clk(clk), .rst(rst), .set(abort_prot), .clr(clr), .flag(prot_err)); // [R10]

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r  <= FOSR_IDLE;
      op_r     <= FOSR_OP_PROGRAM;
      pulses_r <= '0;
      vcnt_r   <= '0;
    end else begin
      unique case (state_r)
        FOSR_IDLE: begin
          if (accept && supply_ok && !cmd.protected_blk && !sticky_any) begin
            state_r  <= FOSR_PULSE;
            op_r     <= cmd.op;
            pulses_r <= '0;
          end
        end
        FOSR_PULSE: begin
          if (cmd.suspend) begin
            state_r <= FOSR_SUSP;
          end else begin
            pulses_r <= pulses_r + PULSE_W'(1);
            vcnt_r   <= '0;
            state_r  <= FOSR_VERIFY;
          end
        end
        FOSR_VERIFY: begin
          if (vcnt_r != 2'(VERIFY_CYC)) begin
            vcnt_r <= vcnt_r + 2'd1;
          end else if (verify_pass || op_r == FOSR_OP_PROGRAM
                       || pulses_r >= PULSE_W'(MAX_PULSE)) begin
            state_r <= FOSR_IDLE;
          end else begin
            state_r <= FOSR_PULSE;
          end
        end
        FOSR_SUSP: begin
          if (cmd.resume) begin
            state_r <= FOSR_PULSE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Suspend flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ers_susp_r <= 1'b0;
      prg_susp_r <= 1'b0;
    end else if (state_r == FOSR_PULSE && cmd.suspend) begin
      ers_susp_r <= op_r == FOSR_OP_ERASE;                   // [R13]
      prg_susp_r <= op_r == FOSR_OP_PROGRAM;                 // [R6]
    end else if (state_r == FOSR_SUSP && cmd.resume) begin
      ers_susp_r <= 1'b0;                                    // [R13]
      prg_susp_r <= 1'b0;                                    // [R8]
    end
  end

  assign pulse_en = state_r == FOSR_PULSE;

  // ==========================================================
  // Status word; host trusts suspend bits only when ready     [R7]
  always_comb begin
    status_live               = RESERVED_VALUE;              // [R11]
    status_live[POS_READY]    = state_r == FOSR_IDLE || state_r == FOSR_SUSP; // [R12]
    status_live[POS_ERS_SUSP] = ers_susp_r;
    status_live[POS_ERS_ERR]  = ers_err;
    status_live[POS_PRG_ERR]  = prg_err;
    status_live[POS_SUPPLY]   = sup_err;
    status_live[POS_PRG_SUSP] = prg_susp_r;
    status_live[POS_PROTECT]  = prot_err;
  end

  // Snapshot updates on each read strobe, as the pins refresh it
  always_ff @(posedge clk) begin
    if (rst) begin
      status_dq <= STATUS_RESET;
    end else if (status_rd) begin
      status_dq <= status_live;
    end
  end

  // ==========================================================
  // Checks
  busy_flag_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == FOSR_PULSE || state_r == FOSR_VERIFY) |-> !status_live[POS_READY])
    else $error("ready bit high while busy"); // [R12]
  supply_abort_a: assert property (@(posedge clk) disable iff (rst)
    abort_supply |=> status_live[POS_SUPPLY] && state_r == FOSR_IDLE)
    else $error("low supply not flagged or not aborted"); // [R2]
  supply_hold_a: assert property (@(posedge clk) disable iff (rst)
    $fell(sup_err) |-> $past(clr) || $past(rst))
    else $error("supply flag dropped without clear"); // [R3]
  protect_abort_a: assert property (@(posedge clk) disable iff (rst)
    abort_prot |=> status_live[POS_PROTECT] && state_r == FOSR_IDLE)
    else $error("protected block not flagged"); // [R9]
  protect_hold_a: assert property (@(posedge clk) disable iff (rst)
    $fell(prot_err) |-> $past(clr) || $past(rst))
    else $error("protect flag dropped without clear"); // [R10]
  sticky_fail_a: assert property (@(posedge clk) disable iff (rst)
    (accept && sticky_any && !clr) |=> state_r == FOSR_IDLE && (prg_err || ers_err))
    else $error("new command ran despite pending error"); // [R4]
  resume_clear_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == FOSR_SUSP && cmd.resume) |=> !prg_susp_r && !ers_susp_r)
    else $error("suspend flag kept after resume"); // [R8]
  prg_susp_a: assert property (@(posedge clk) disable iff (rst)
    prg_susp_r |-> state_r == FOSR_SUSP && op_r == FOSR_OP_PROGRAM)
    else $error("program suspend flag wrong"); // [R6]
  clear_keep_a: assert property (@(posedge clk) disable iff (rst)
    clr |=> (status_live & ~STICKY_MASK & 8'hFE) == ($past(status_live) & ~STICKY_MASK & 8'hFE)
      && (status_live & STICKY_MASK) == 8'h00)
    else $error("clear touched wrong bits"); // [R16]
  reserved_a: assert property (@(posedge clk) disable iff (rst) !status_live[0])
    else $error("reserved bit set"); // [R11]
  idle_ready_a: assert property (@(posedge clk) disable iff (rst)
    state_r == FOSR_IDLE |-> status_live[POS_READY])
    else $error("ready bit low while idle"); // [R12]
  ers_susp_a: assert property (@(posedge clk) disable iff (rst)
    ers_susp_r |-> state_r == FOSR_SUSP && op_r == FOSR_OP_ERASE)
    else $error("erase suspend flag wrong"); // [R13]
  // Sticky rises are traced back to the start or the verify step that caused them
  supply_once_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sup_err) |-> $past(accept) && !$past(supply_ok))
    else $error("supply flag set outside a start"); // [R1]
  protect_once_a: assert property (@(posedge clk) disable iff (rst)
    $rose(prot_err) |-> $past(accept) && $past(cmd.protected_blk))
    else $error("protect flag set outside a start"); // [R9]
  prog_result_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == FOSR_VERIFY && vcnt_r == 2'(VERIFY_CYC) && op_r == FOSR_OP_PROGRAM)
    |=> state_r == FOSR_IDLE && prg_err == !$past(verify_pass))
    else $error("program result flag wrong"); // [R15]
  erase_result_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == FOSR_VERIFY && vcnt_r == 2'(VERIFY_CYC) && op_r == FOSR_OP_ERASE
     && !verify_pass) |=> ers_err == ($past(pulses_r) >= PULSE_W'(MAX_PULSE)))
    else $error("erase failure flag wrong"); // [R14]
endmodule

// File: fosr_array_model.sv
// Array verify model facing the status block's pulse and verify ports
`timescale 1ns/1ns
module fosr_array_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       clr_cnt,
  input  wire logic       pulse_en,
  input  wire logic [7:0] need,
  // Verify result
  output logic            verify_pass
);
  // ==========================================================
  // Pulse counting
  logic [7:0] cnt_r;
  logic       pulse_d_r;
  always_ff @(posedge clk) begin
    pulse_d_r <= pulse_en;
    if (clr_cnt) begin
      cnt_r <= 8'h00;
    end else if (pulse_en && !pulse_d_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // A weak cell verifies only after several pulses; 8'hFF verifies only after 255 pulses
  assign verify_pass = (cnt_r >= need);
endmodule

// File: flash_op_status_register_test.sv
// Self-checking bench for the flash operation status block
`timescale 1ns/1ns
module flash_op_status_register_test;
  import fosr_pkg::*;
  // ==========================================================
  // Signals
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                supply_ok = 1'b1;
  logic                status_rd = 1'b0;
  logic                clr_cnt = 1'b1;
  logic [7:0]          need = 8'h01;
  fosr_cmd_s           cmd = '0;
  logic                verify_pass;
  logic                pulse_en;
  logic [STATUS_W-1:0] status_dq;
  logic [STATUS_W-1:0] status_live;
  int                  error_cnt = 0;
  int                  num_checks = 0;

  fosr_status #(.MAX_PULSE(3)) i_dut (.clk(clk), .rst(rst), .cmd(cmd), .supply_ok(supply_ok),
    .verify_pass(verify_pass), .status_rd(status_rd), .status_dq(status_dq),
    .status_live(status_live), .pulse_en(pulse_en));
  fosr_array_model i_array (.clk(clk), .clr_cnt(clr_cnt), .pulse_en(pulse_en), .need(need),
    .verify_pass(verify_pass));

  initial begin
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic step;
    @(posedge clk);
    #5;
  endtask

  task automatic wait_ready;
    int i;
    for (i = 0; i < 200 && status_live[POS_READY] !== 1'b1; i++) step();
    if (i == 200) begin
      $display("wrong value ready expected 1 seen timeout");
      error_cnt++;
      end_sim();
    end
  endtask

  // The counter reset rides on the start cycle so each run counts its own pulses
  task automatic run(fosr_op_e op, logic prot, logic sup, logic [7:0] n);
    need = n;
    supply_ok = sup;
    cmd.op = op;
    cmd.protected_blk = prot;
    cmd.start = 1'b1;
    clr_cnt = 1'b1;
    step();
    cmd.start = 1'b0;
    clr_cnt = 1'b0;
  endtask

  task automatic read_chk(string name, logic [7:0] exp);
    wait_ready();
    status_rd = 1'b1;
    step();
    status_rd = 1'b0;
    chk(name, exp, status_dq);
  endtask

  task automatic clear_st;
    cmd.clear_status = 1'b1;
    step();
    cmd.clear_status = 1'b0;
    step();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) step();
    rst = 1'b0;
    chk("reset", 8'h80, status_live);
    chk("reset dq", 8'h80, status_dq);
    run(FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'h01);
    chk("busy", 8'h00, status_live & 8'h80);
    chk("pulse", 8'h01, {7'h00, pulse_en});
    read_chk("prog ok", 8'h80);
    run(FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'h01);
    supply_ok = 1'b0;
    read_chk("supply once", 8'h80);
    run(FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'hFF);
    read_chk("prog fail", 8'h90);
    run(FOSR_OP_ERASE, 1'b0, 1'b1, 8'h01);
    read_chk("pending", 8'hB0);
    clear_st();
    read_chk("clear", 8'h80);
    run(FOSR_OP_ERASE, 1'b0, 1'b1, 8'hFF);
    read_chk("erase fail", 8'hA0);
    clear_st();
    run(FOSR_OP_ERASE, 1'b0, 1'b1, 8'h03);
    read_chk("erase retry", 8'h80);
    run(FOSR_OP_PROGRAM, 1'b0, 1'b0, 8'h01);
    read_chk("low supply", 8'h88);
    chk("no pulse", 8'h00, {7'h00, pulse_en});
    run(FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'h01);
    read_chk("supply held", 8'h98);
    clear_st();
    run(FOSR_OP_ERASE, 1'b1, 1'b1, 8'h01);
    read_chk("protect", 8'h82);
    run(FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'h01);
    read_chk("protect held", 8'h92);
    clear_st();
    read_chk("clear all", 8'h80);
    for (int k = 0; k < 2; k++) begin
      run(k ? FOSR_OP_ERASE : FOSR_OP_PROGRAM, 1'b0, 1'b1, 8'h01);
      cmd.suspend = 1'b1;
      step();
      cmd.suspend = 1'b0;
      read_chk("suspend", k ? 8'hC0 : 8'h84);
      clear_st();
      read_chk("clear in suspend", k ? 8'hC0 : 8'h84);
      cmd.resume = 1'b1;
      step();
      cmd.resume = 1'b0;
      chk("resume", 8'h00, status_live & 8'h44);
      read_chk("resumed done", 8'h80);
    end
    end_sim();
  end
endmodule
